/* File: rtl/cfl_loader.v */
`timescale 1ns/1ps
`default_nettype none
`include "cfl_defines.vh"
module cfl_loader #(
   parameter [31:0] DELAY_CYC = `CFL_DELAY_CYC
) (
   // Clock and power-on reset
   input wire i_core_clk,
   input wire i_resetn,
   // Pins
   input wire i_config_clock,
   input wire i_data,
   input wire i_mode_select_bit0,
   input wire i_program_n,
   input wire i_wait_n,
   output reg o_wait_n_out,
   output reg o_wait_n_oe,
   // Status and options
   input wire i_supply_ok,
   input wire i_bit_test_ok,
   input wire i_crc_en,
   input wire i_extended,
   input wire [5:0] i_rows,
   input wire [5:0] i_cols,
   // Frame data out, one frame word per bit with marker
   output reg o_frame_valid,
   output reg o_frame_bit,
   input wire i_frame_ready,
   // Readback
   input wire i_rb_start,
   input wire i_rb_valid,
   input wire i_rb_bit,
   input wire i_rb_last,
   output reg o_rb_valid,
   output reg o_rb_bit,
   // Phase status
   output reg [2:0] o_phase,
   output reg o_error,
   output reg o_startup
);
   localparam ST_POWER = 3'h0;
   localparam ST_CLEAR = 3'h1;
   localparam ST_INIT = 3'h2;
   localparam ST_LOAD = 3'h3;
   localparam ST_START = 3'h4;
   localparam ST_ERROR = 3'h5;
   localparam LD_PRE = 2'h0;
   localparam LD_LEN = 2'h1;
   localparam LD_FRAME = 2'h2;
   localparam LD_POST = 2'h3;

   // Pin synchronisers
   reg [1:0] config_clock_s;
   reg [1:0] data_s;
   reg [1:0] m0_s;
   reg [1:0] prog_s;
   reg [1:0] wait_s;
   reg config_clock_d;
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         config_clock_s <= 2'h0;
         data_s <= 2'h0;
         m0_s <= 2'h3;
         prog_s <= 2'h3;
         wait_s <= 2'h0;
         config_clock_d <= 1'b0;
      end else begin
         config_clock_s <= {config_clock_s[0], i_config_clock};
         data_s <= {data_s[0], i_data};
         m0_s <= {m0_s[0], i_mode_select_bit0};
         prog_s <= {prog_s[0], i_program_n};
         wait_s <= {wait_s[0], i_wait_n};
         config_clock_d <= config_clock_s[1];
      end
   end
   wire config_clock_rise = config_clock_s[1] && !config_clock_d;
   wire din = data_s[1];

   // Frame geometry
   // Twelve bits hold the largest array either family can name
   wire [11:0] base_len = 12'd`CFL_BASE_ROW * {6'h00, i_rows} +
      12'd`CFL_BASE_FIX;
   wire [11:0] ext_len = 12'd`CFL_EXT_ROW * {6'h00, i_rows} +
      12'd`CFL_EXT_FIX;
   wire [11:0] base_cnt = 12'd`CFL_BASE_COL * {6'h00, i_cols} +
      12'd`CFL_BASE_FRM_FIX;
   wire [11:0] ext_cnt = 12'd`CFL_EXT_COL * {6'h00, i_cols} +
      12'd`CFL_EXT_FRM_FIX;
   wire [11:0] frame_len = i_extended ? ext_len : base_len;
   wire [11:0] frame_cnt = i_extended ? ext_cnt : base_cnt;
   wire [3:0] post_len = i_extended ? 4'd`CFL_EXT_POST :
      4'd`CFL_BASE_POST;

   reg [2:0] phase;
   reg [1:0] ld;
   reg [31:0] timer;
   reg clear_pass;
   reg powered;
   reg [23:0] len_count;
   reg [23:0] clk_count;
   reg [3:0] shreg;
   reg [4:0] len_bits;
   reg started;
   reg [11:0] bit_idx;
   reg [11:0] frm_idx;
   reg [3:0] chk;
   reg [15:0] crc;
   reg [3:0] post_idx;
   reg mem_full;

   // CCITT CRC step, one bit at a time
   function [15:0] crc_step;
      input [15:0] c;
      input b;
      begin
         crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CFL_CRC_POLY : 16'h0);
      end
   endfunction

   wire [31:0] delay_goal = m0_s[1] ? DELAY_CYC :
      DELAY_CYC * `CFL_MASTER_MULT;
   wire [11:0] data_end = frame_len - 12'd`CFL_CHK_BITS;
   wire in_chk = (bit_idx >= data_end);
   wire [3:0] next_chk = {chk[2:0], din};
   // Partial check: top four bits of running CRC
   wire chk_ok = i_crc_en ? (next_chk == crc[15:12]) :
      (next_chk == `CFL_EOF_PATTERN);

   // Frame bits go through the buffer; its ready stalls bit acceptance
   wire fifo_ready;
   wire fifo_valid;
   wire fifo_bit;
   // Output word refills when empty or taken, so a pop is always seen
   wire out_free = !o_frame_valid || i_frame_ready;
   wire take = config_clock_rise && fifo_ready;
   wire push_bit = (phase == ST_LOAD) && (ld == LD_FRAME) && take &&
      (bit_idx != 12'h0) && !in_chk;

   cfl_fifo #(
      .WIDTH(1),
      .DEPTH(`CFL_FIFO_DEPTH),
      .AW(`CFL_FIFO_AW)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_valid(push_bit),
      .i_data(din),
      .o_ready(fifo_ready),
      .o_valid(fifo_valid),
      .o_data(fifo_bit),
      .i_ready(out_free)
   );

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         phase <= ST_POWER;
         ld <= LD_PRE;
         timer <= 32'h0;
         clear_pass <= 1'b0;
         powered <= 1'b0;
         len_count <= 24'h0;
         clk_count <= 24'h0;
         shreg <= 4'hf;
         len_bits <= 5'h0;
         started <= 1'b0;
         bit_idx <= 12'h0;
         frm_idx <= 12'h0;
         chk <= 4'h0;
         crc <= `CFL_CRC_INIT;
         post_idx <= 4'h0;
         mem_full <= 1'b0;
      end else begin
         case (phase)
            ST_POWER: begin
               if (i_supply_ok && i_bit_test_ok) begin
                  phase <= ST_CLEAR;
                  timer <= 32'h0;
               end
            end
            ST_CLEAR: begin
               clear_pass <= ~clear_pass;
               if (!prog_s[1]) begin
                  timer <= 32'h0;
               end else if (!powered && timer < delay_goal) begin
                  timer <= timer + 32'h1;
               end else begin
                  powered <= 1'b1;
                  phase <= ST_INIT;
               end
            end
            ST_INIT: begin
               if (!prog_s[1]) begin
                  phase <= ST_CLEAR;
               end else if (wait_s[1]) begin
                  phase <= ST_LOAD;
                  ld <= LD_PRE;
                  shreg <= 4'hf;
                  clk_count <= 24'h0;
                  len_bits <= 5'h0;
                  started <= 1'b0;
                  mem_full <= 1'b0;
                  crc <= `CFL_CRC_INIT;
               end
            end
            ST_LOAD: begin
               if (!prog_s[1]) begin
                  phase <= ST_CLEAR;
               end else if (take) begin
                  clk_count <= clk_count + 24'h1;
                  case (ld)
                     LD_PRE: begin
                        shreg <= {shreg[2:0], din};
                        if ({shreg[2:0], din} == `CFL_PREAMBLE) begin
                           ld <= LD_LEN;
                           len_bits <= 5'h0;
                        end
                     end
                     LD_LEN: begin
                        len_count <= {len_count[22:0], din};
                        len_bits <= len_bits + 5'h1;
                        if (len_bits == 5'd`CFL_LEN_BITS - 5'h1) begin
                           ld <= LD_FRAME;
                           bit_idx <= 12'h0;
                           frm_idx <= 12'h0;
                           started <= 1'b0;
                        end
                     end
                     LD_FRAME: begin
                        if (bit_idx == 12'h0) begin
                           // Leading ones are fill; a zero starts the frame
                           if (!din) begin
                              bit_idx <= 12'h1;
                           end
                        end else begin
                           if (!in_chk) begin
                              crc <= crc_step(crc, din);
                           end
                           chk <= next_chk;
                           if (bit_idx == frame_len - 12'h1) begin
                              bit_idx <= 12'h0;
                              if (!chk_ok) begin
                                 phase <= ST_ERROR;
                              end else if (frm_idx == frame_cnt - 12'h1) begin
                                 ld <= LD_POST;
                                 post_idx <= 4'h0;
                              end else begin
                                 frm_idx <= frm_idx + 12'h1;
                              end
                           end else begin
                              bit_idx <= bit_idx + 12'h1;
                           end
                        end
                     end
                     LD_POST: begin
                        if (post_idx == post_len - 4'h1) begin
                           mem_full <= 1'b1;
                        end else begin
                           post_idx <= post_idx + 4'h1;
                        end
                     end
                     default: ld <= LD_PRE;
                  endcase
               end else if (mem_full && clk_count == len_count) begin
                  phase <= ST_START;
               end
            end
            ST_START: begin
               if (!prog_s[1]) begin
                  phase <= ST_CLEAR;
               end
            end
            ST_ERROR: begin
               if (!prog_s[1]) begin
                  phase <= ST_CLEAR;
               end
            end
            default: phase <= ST_POWER;
         endcase
      end
   end

   // Readback checksum: stream then upper eleven CRC bits
   reg [15:0] rb_crc;
   reg [3:0] rb_cnt;
   reg rb_tail;
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rb_crc <= `CFL_CRC_INIT;
         rb_cnt <= 4'h0;
         rb_tail <= 1'b0;
         o_rb_valid <= 1'b0;
         o_rb_bit <= 1'b0;
      end else begin
         o_rb_valid <= 1'b0;
         if (i_rb_start) begin
            rb_crc <= `CFL_CRC_INIT;
            rb_tail <= 1'b0;
         end else if (rb_tail) begin
            o_rb_valid <= 1'b1;
            o_rb_bit <= rb_crc[15];
            rb_crc <= {rb_crc[14:0], 1'b0};
            if (rb_cnt == 4'd`CFL_RB_BITS - 4'h1) begin
               rb_tail <= 1'b0;
            end
            rb_cnt <= rb_cnt + 4'h1;
         end else if (i_rb_valid) begin
            o_rb_valid <= 1'b1;
            o_rb_bit <= i_rb_bit;
            rb_crc <= crc_step(rb_crc, i_rb_bit);
            if (i_rb_last) begin
               rb_tail <= 1'b1;
               rb_cnt <= 4'h0;
            end
         end
      end
   end

   // Registered outputs
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wait_n_out <= 1'b0;
         o_wait_n_oe <= 1'b1;
         o_frame_valid <= 1'b0;
         o_frame_bit <= 1'b0;
         o_phase <= ST_POWER;
         o_error <= 1'b0;
         o_startup <= 1'b0;
      end else begin
         o_wait_n_out <= 1'b0;
         // Wire held low through clear, released for the wait, pulled on error
         o_wait_n_oe <= (phase == ST_POWER) || (phase == ST_CLEAR) ||
            (phase == ST_ERROR);
         if (out_free) begin
            o_frame_valid <= fifo_valid;
            o_frame_bit <= fifo_bit;
         end
         o_phase <= phase;
         o_error <= (phase == ST_ERROR);
         o_startup <= (phase == ST_START);
      end
   end
endmodule
`default_nettype wire

/* File: rtl/cfl_defines.vh */
// What this block does
// - Every frame ends with a four-bit check field after its data bits.
// - A frame error abandons loading, pulls the wait pin low, and waits.
// - Readback appends eleven bits of a sixteen-bit checksum to its stream.
// - Checksum is CRC-16 CCITT; appended bits are its upper eleven.
// - Base family frame and frame-count formulas from rows and columns.
// - Extended family frame and frame-count formulas from rows and columns.
// - Program data is length times count plus eight or five postamble bits.
// - Wait for supply and a bit-pair write-read test before the delay.
// - Power-up delay nominally 16 ms, ten percent longer in low voltage; CFL_DELAY_CYC always uses the longer figure.
// - Master mode (mode select bit zero low) makes the delay four times longer.
// - Wired-together wait pins stay low until the longest delay releases.
// - Power-up delay only after power application, not on reconfiguration.
// - Phases in order: clear, initialization, load, start-up.
// - After the 0010 preamble the next 24 bits are the length count.
// - Without CRC each frame check field must equal 0110.
// - With CRC a running CRC is compared with each four-bit partial check.
// - Start-up once memory full and clocks counted equal the length count.
`ifndef CFL_DEFINES_VH
`define CFL_DEFINES_VH
`define CFL_CLK_MHZ 200
`define CFL_DELAY_US 16000
`define CFL_DELAY_LV_PCT 110
`define CFL_MASTER_MULT 4
`define CFL_DELAY_CYC ((`CFL_DELAY_US * `CFL_CLK_MHZ * `CFL_DELAY_LV_PCT) / 100)
`define CFL_PREAMBLE 4'h2
`define CFL_LEN_BITS 24
`define CFL_CHK_BITS 4
`define CFL_EOF_PATTERN 4'h6
`define CFL_CRC_POLY 16'h1021
`define CFL_CRC_INIT 16'h0000
`define CFL_RB_BITS 11
`define CFL_BASE_ROW 10
`define CFL_BASE_FIX 26
`define CFL_BASE_COL 36
`define CFL_BASE_FRM_FIX 68
`define CFL_BASE_POST 8
`define CFL_EXT_ROW 13
`define CFL_EXT_FIX 39
`define CFL_EXT_COL 47
`define CFL_EXT_FRM_FIX 83
`define CFL_EXT_POST 5
`define CFL_FIFO_DEPTH 16
`define CFL_FIFO_AW 4
`endif

/* File: rtl/cfl_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module cfl_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_resetn,
   // Fill side
   input wire i_valid,
   input wire [WIDTH-1:0] i_data,
   output wire o_ready,
   // Drain side
   output wire o_valid,
   output wire [WIDTH-1:0] o_data,
   input wire i_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   assign o_ready = (count != DEPTH[AW:0]);
   assign o_valid = (count != {(AW+1){1'b0}});
   assign o_data = mem[rd_ptr];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   always @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/cfl_loader_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cfl_loader_props #(
   parameter [31:0] DELAY_CYC = 32'd20
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Power and pins
   input wire logic i_supply_ok,
   input wire logic i_bit_test_ok,
   input wire logic i_mode_select_bit0,
   input wire logic i_wait_n,
   input wire logic o_wait_n_out,
   input wire logic o_wait_n_oe,
   // Status
   input wire logic [2:0] o_phase,
   input wire logic o_error,
   input wire logic o_startup,
   // Readback
   input wire logic i_rb_valid,
   input wire logic i_rb_last,
   input wire logic o_rb_valid
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   logic [33:0] dly;
   logic [33:0] pw_cnt;
   logic left_pw;
   assign dly = i_mode_select_bit0 ? 34'(DELAY_CYC) : 34'(DELAY_CYC) * 4;
   // Counts from both power flags; the design sees them in the same cycle, never sooner
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pw_cnt <= 34'h0;
         left_pw <= 1'b0;
      end else begin
         if (i_supply_ok && i_bit_test_ok && !left_pw)
            pw_cnt <= pw_cnt + 34'h1;
         if (o_phase >= 3'h2)
            left_pw <= 1'b1;
      end
   end
   power_hold_a: assert property (!(i_supply_ok && i_bit_test_ok) && o_phase == 3'h0 |=> o_phase == 3'h0)
      else $error("phase left power state early");
   delay_min_a: assert property (o_phase >= 3'h2 && !left_pw |-> pw_cnt >= dly)
      else $error("power-up delay too short");
   phase_step_a: assert property (o_phase != $past(o_phase) |-> o_phase == $past(o_phase) + 3'h1 || o_phase inside {3'h1, 3'h5})
      else $error("phase order broken");
   wait_hold_a: assert property (o_phase == 3'h2 && !i_wait_n |=> o_phase == 3'h2)
      else $error("left init while wait wire low");
   err_pull_a: assert property (o_phase == 3'h5 |=> o_wait_n_oe && !o_wait_n_out)
      else $error("wait pin not pulled on error");
   err_flag_a: assert property ($rose(o_error) |-> ##[0:1] o_phase == 3'h5)
      else $error("error flag without error phase");
   start_phase_a: assert property ($rose(o_startup) |-> ##[0:1] o_phase == 3'h4)
      else $error("startup flag outside startup");
   rb_tail_a: assert property (i_rb_valid && i_rb_last |=> o_rb_valid [*8] ##1 o_rb_valid [*4] ##1 !o_rb_valid)
      else $error("readback tail not eleven bits");
endmodule
bind cfl_loader cfl_loader_props #(.DELAY_CYC(DELAY_CYC)) u_props (.*);
`default_nettype wire

/* File: test/cfl_source.sv */
`timescale 1ns/1ps
`default_nettype none
module cfl_source (
   // Link pins
   output logic o_clk,
   output logic o_data
);
   initial begin
      o_clk = 1'b0;
      o_data = 1'b1;
   end
   // Clock stands still between bits; stale data is inverted
   task send(input logic b);
      begin
         o_data = b;
         #12 o_clk = 1'b1;
         #24 o_clk = 1'b0;
         #6 o_data = ~b;
         #6;
      end
   endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b1;
   logic i_supply_ok = 1'b0, i_bit_test_ok = 1'b0;
   logic i_mode_select_bit0 = 1'b0, i_program_n = 1'b1;
   logic i_extended = 1'b0, hold_low = 1'b1, i_frame_ready = 1'b0;
   logic i_rb_start = 1'b0, i_rb_valid = 1'b0, i_rb_bit = 1'b0;
   logic i_rb_last = 1'b0, i_crc_en = 1'b0;
   logic [5:0] i_rows = 6'h03, i_cols = 6'h00;
   wire i_config_clock, i_data, o_wait_n_out, o_wait_n_oe;
   wire o_frame_valid, o_frame_bit, o_rb_valid, o_rb_bit;
   wire o_error, o_startup;
   wire [2:0] o_phase;
   // Shared open-drain wait wire
   wire i_wait_n = !(o_wait_n_oe && !o_wait_n_out) && !hold_low;
   integer seed = 62, miscompares = 0, samples_checked = 0;
   logic [2:0] pq[$], fq[$], rq[$];
   logic [2:0] ph_seen = 3'h0;
   always #2.5 i_core_clk = ~i_core_clk;
   cfl_source src (.o_clk(i_config_clock), .o_data(i_data));
   cfl_loader #(.DELAY_CYC(32'd2500)) DUT (.*);
   task automatic cmp(input string nm, ref logic [2:0] q[$],
                      input logic [2:0] g);
      logic [2:0] e;
      begin
         e = q.size() ? q.pop_front() : 3'bzzz;
         samples_checked++;
         if (e !== g) begin
            miscompares++;
            $display("BAD %s exp %b got %b", nm, e, g);
         end
      end
   endtask
   // Ready at random; every taken output word outside the error phase is compared
   always @(posedge i_core_clk) begin
      i_frame_ready <= !i_frame_ready && ($random(seed) & 1);
      if (i_resetn) begin
         if (o_phase !== ph_seen) cmp("phase", pq, o_phase);
         if (o_frame_valid && i_frame_ready && o_phase != 3'h5)
            cmp("frame", fq, {2'b0, o_frame_bit});
         if (o_rb_valid) cmp("rb", rq, {2'b0, o_rb_bit});
      end
      ph_seen <= o_phase;
   end
   task wph(input logic [2:0] p, input integer n);
      integer t;
      begin
         t = 0;
         while (o_phase !== p && t < n) begin
            @(posedge i_core_clk);
            t++;
         end
         samples_checked++;
         if (t >= n) begin
            miscompares++;
            $display("BAD phase_wait exp %0d got %0d", p, o_phase);
         end
      end
   endtask
   task load(input integer bad);
      integer fl, nf, i, k, pad;
      logic [31:0] hd;
      logic [15:0] c;
      logic b;
      begin
         c = 16'h0000;
         fl = i_extended ? 13 * i_rows + 39 : 10 * i_rows + 26;
         nf = i_extended ? 47 * i_cols + 83 : 36 * i_cols + 68;
         pad = $random(seed) & 3;
         hd = {4'h2, 24'(pad + 40 + fl * nf + (i_extended ? 5 : 8)), 4'hf};
         repeat (8 + pad) src.send(1'b1);
         for (k = 31; k >= 0; k--) src.send(hd[k]);
         for (i = 0; i < nf && (bad < 0 || i <= bad); i++) begin
            src.send(1'b0);
            repeat (fl - 5) begin
               b = 1'($random(seed));
               fq.push_back({2'b0, b});
               c = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? 16'h1021 : 16'h0);
               src.send(b);
            end
            hd[3:0] = i_crc_en ? c[15:12] : 4'h6;
            if (i == bad) hd[3:0] = ~hd[3:0];
            for (k = 3; k >= 0; k--) src.send(hd[k]);
         end
         if (bad < 0) begin
            src.send(1'b0);
            repeat ((i_extended ? 5 : 8) - 1) src.send(1'b1);
         end
      end
   endtask
   task rb(input integer n);
      logic [15:0] c;
      logic b;
      integer k;
      begin
         c = 16'h0000;
         i_rb_start <= 1'b1;
         @(posedge i_core_clk);
         i_rb_start <= 1'b0;
         for (k = 0; k < n; k++) begin
            b = 1'($random(seed));
            i_rb_valid <= 1'b1;
            i_rb_bit <= b;
            i_rb_last <= (k == n - 1);
            rq.push_back({2'b0, b});
            c = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? 16'h1021 : 16'h0);
            @(posedge i_core_clk);
         end
         i_rb_valid <= 1'b0;
         i_rb_last <= 1'b0;
         for (k = 15; k >= 5; k--) rq.push_back({2'b0, c[k]});
         repeat (20) @(posedge i_core_clk);
      end
   endtask
   task end_sim;
      begin
         $display("checked %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #450000;
      miscompares++;
      $display("BAD watchdog exp done got hang");
      end_sim;
   end
   initial begin
      #1 i_resetn = 1'b0;
      pq = '{3'h1, 3'h2, 3'h3};
      repeat (16) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      repeat (10) @(posedge i_core_clk);
      i_supply_ok <= 1'b1;
      repeat (10) @(posedge i_core_clk);
      i_bit_test_ok <= 1'b1;
      wph(3'h2, 20000);
      repeat (50) @(posedge i_core_clk);
      hold_low <= 1'b0;
      i_crc_en <= 1'b1;
      i_cols <= 6'($random(seed));
      wph(3'h3, 1000);
      $display("test powerup done");
      pq.push_back(3'h5);
      load(1);
      wph(3'h5, 1000);
      fq.delete();
      $display("test frame_error done");
      pq = {pq, 3'h1, 3'h2, 3'h3};
      i_program_n <= 1'b0;
      repeat (10) @(posedge i_core_clk);
      i_program_n <= 1'b1;
      wph(3'h3, 5000);
      i_extended <= 1'b1;
      i_rows <= 6'h00;
      i_cols <= 6'h00;
      i_crc_en <= 1'b0;
      pq.push_back(3'h4);
      @(posedge i_core_clk);
      load(-1);
      wph(3'h4, 2000);
      $display("test ext_load done");
      rb(40);
      rb(97);
      $display("test readback done");
      i_resetn <= 1'b0;
      i_mode_select_bit0 <= 1'b1;
      i_supply_ok <= 1'b0;
      i_bit_test_ok <= 1'b0;
      pq = '{3'h1, 3'h2, 3'h3};
      repeat (16) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_supply_ok <= 1'b1;
      i_bit_test_ok <= 1'b1;
      wph(3'h3, 5000);
      $display("test reset_again done");
      end_sim;
   end
endmodule
`default_nettype wire
